// ---- core/gpio_port.sv ----
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ns
`default_nettype none
module gpio_port
    import gpio_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // general pins
    input wire logic [5:0] pinIn,
    output logic [5:0] pinOut,
    output logic [5:0] pinOe,
    output logic [5:0] pullEn,
    // eeprom link, open drain
    input wire logic eeDataIn,
    output logic eeDataOut,
    output logic eeDataOe,
    input wire logic eeClockIn,
    output logic eeClockOut,
    output logic eeClockOe,
    // change detect
    output logic changeFlag
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] status_r;
    logic [7:0] latch_r;
    logic [7:0] intCtl_r;
    logic [7:0] option_r;
    logic [5:0] dir_r;
    logic [7:0] config_r;
    logic [4:0] analog_r;
    logic [7:0] snap_r;
    wire [7:0] level_r;
    logic [CLOCK_OUTPUT_PIN_DIV_BITS-1:0] div_r;
    logic [31:0] readdata_r;
    logic waitreq_r;
    logic [5:0] pinOut_r;
    logic [5:0] pinOe_r;
    logic [5:0] pullEn_r;
    logic eeDataOe_r;
    logic eeClockOe_r;
    logic changeFlag_r;

    // ------------------------------------------------------------
    // input synchronisers, three stages per line
    // ------------------------------------------------------------
    wire [7:0] rawIn = {eeClockIn, eeDataIn, pinIn};

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            // each line keeps its own stages, so no vector has two writers
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic lvl_r;
            always_ff @(posedge mclk) begin
                if (rst) begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                    lvl_r <= 1'b1;
                end else begin
                    s1_r <= rawIn[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    // a change counts once stages two and three agree
                    if (s2_r == s3_r) begin
                        lvl_r <= s3_r;
                    end
                end
            end
            assign level_r[gi] = lvl_r;
        end
    endgenerate

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    wire [2:0] oscMode = config_r[CFG_OSC_LSB +: 3];
    wire rcMode = (oscMode == OSC_EXTERNAL_RC_OSC_MODE) || (oscMode == OSC_INTERNAL_RC_OSC_MODE);
    wire mclrMode = config_r[CFG_MASTER_CLEAR_INPUT_BIT];
    wire clkOutMode = rcMode && config_r[CFG_CLOCK_OUTPUT_PIN_BIT];
    // pins 0,1,2 and 4 as analog inputs
    wire [5:0] analogMask = {1'b0, analog_r[4], 1'b0, analog_r[2:0]};

    // alternate functions take the pin away from the port
    wire [5:0] altMask;
    // oscillator owns pins four and five
    assign altMask = analogMask
                   | (rcMode ? 6'h00 : OSC_PIN_MASK)
                   | (clkOutMode ? 6'h10 : 6'h00)
                   | (mclrMode ? 6'h08 : 6'h00);

    // direction as seen by software and by the drivers
    wire [5:0] dirEff;
    // oscillator pins forced to one outside RC
    assign dirEff = {rcMode ? dir_r[5] : 1'b1,
                     rcMode ? dir_r[4] : 1'b1,
                     1'b1,
                     dir_r[2:0]};

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // only word-aligned byte addresses hit; other offsets read zero
    wire hitStatus = (address == {STATUS_IDX, 2'b00});
    wire hitPort = (address == {PORT_IDX, 2'b00});
    wire hitIntCtl = (address == {INTCTL_IDX, 2'b00});
    wire hitOption = (address == {OPTION_IDX, 2'b00});
    wire hitDir = (address == {DIR_IDX, 2'b00});
    wire hitConfig = (address == {CONFIG_IDX, 2'b00});
    wire hitAnalog = (address == {ANALOG_IDX, 2'b00});

    // the access completes at the edge that sees waitrequest low
    wire accept = (read || write) && waitreq_r;
    wire doWrite = write && !waitreq_r;
    wire doRead = read && !waitreq_r;
    wire [7:0] wd = writedata[7:0];

    // pins are read, never the latches
    // top bits show the eeprom line levels
    // six general pins under two link bits
    wire [7:0] portView;
    assign portView = {level_r[7:6], level_r[5:0] & ~altMask};

    wire [7:0] readMux;
    assign readMux = hitStatus ? status_r :
                     hitPort ? portView :
                     hitIntCtl ? intCtl_r :
                     hitOption ? option_r :
                     hitDir ? {2'b00, dirEff} :
                     hitConfig ? config_r :
                     hitAnalog ? {3'b000, analog_r} :
                     8'h00;

    // ------------------------------------------------------------
    // change detect
    // ------------------------------------------------------------
    wire [5:0] groupEn;
    // one enable for the whole group
    // master clear pin leaves the group
    assign groupEn = mclrMode ? (GROUP_MASK & ~6'h08) : GROUP_MASK;
    // only with the enable bit set
    // compare against the last read snapshot
    wire changeSet = intCtl_r[CHG_EN_BIT]
                   && |((level_r[5:0] ^ snap_r[5:0]) & groupEn);

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    // one wait state always: readdata is registered at the request
    // edge, so a read shows register state one cycle before the answer
    always_ff @(posedge mclk) begin
        if (rst) begin
            waitreq_r <= 1'b1;
            readdata_r <= 32'h0000_0000;
        end else begin
            waitreq_r <= !accept;
            if (accept) begin
                readdata_r <= {24'h00_0000, readMux};
            end
        end
    end

    // ------------------------------------------------------------
    // port latches and read snapshot
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            latch_r <= PORT_RST;
            snap_r <= 8'h00;
        end else if (doWrite && hitPort) begin
            latch_r <= wd;
        // inputs captured only at a read
        // the snapshot is what the change detect compares against
        end else if (doRead && hitPort) begin
            snap_r <= portView;
        end
    end

    // ------------------------------------------------------------
    // direction register
    // ------------------------------------------------------------
    wire [5:0] dirNxt;
    // oscillator bits only in RC modes
    assign dirNxt = {rcMode ? wd[5] : dir_r[5],
                     (rcMode && !clkOutMode) ? wd[4] : dir_r[4],
                     1'b1,
                     wd[2:0]};

    always_ff @(posedge mclk) begin
        if (rst) begin
            dir_r <= DIR_RST;
        end else if (doWrite && hitDir) begin
            dir_r <= dirNxt;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // config and analog stand in for the fuse word and analog select
    always_ff @(posedge mclk) begin
        if (rst) begin
            status_r <= STATUS_RST;
            option_r <= OPTION_RST;
            config_r <= CONFIG_RST;
            analog_r <= ANALOG_RST;
        end else if (doWrite) begin
            if (hitStatus) begin
                // reserved bank bits stay clear
                status_r <= {2'b00, wd[STATUS_KEEP_MSB:0]};
            end
            if (hitOption) begin
                option_r <= wd;
            end
            if (hitConfig) begin
                config_r <= {3'b000, wd[4:0]};
            end
            if (hitAnalog) begin
                analog_r <= wd[4:0];
            end
        end
    end

    // hardware set wins over a software clear of the flag
    always_ff @(posedge mclk) begin
        if (rst) begin
            intCtl_r <= INTCTL_RST;
        end else if (doWrite && hitIntCtl) begin
            intCtl_r <= {wd[7:1], wd[CHG_FLAG_BIT] | changeSet};
        end else if (changeSet) begin
            intCtl_r[CHG_FLAG_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // clock output divider
    // ------------------------------------------------------------
    // free running, so the clock output phase is not tied to any write
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    wire [5:0] oeNxt;
    // zero drives the latch, one tristates
    // input-only pin never driven
    // analog and alternate pins are never driven, whatever the direction, except pin four as the clock output
    assign oeNxt = (~dirEff & ~altMask & ~analogMask & ~6'h08)
                 | (clkOutMode ? 6'h10 : 6'h00);

    wire [5:0] outNxt;
    assign outNxt = clkOutMode
                  ? {latch_r[5], div_r[CLOCK_OUTPUT_PIN_DIV_BITS-1], latch_r[3:0]}
                  : latch_r[5:0];

    wire [5:0] pullNxt;
    // clear bit enables the group pull-ups
    assign pullNxt = (option_r[PULLUP_DIS_BIT] ? 6'h00 : GROUP_MASK)
                   | (mclrMode ? 6'h08 : 6'h00);

    always_ff @(posedge mclk) begin
        if (rst) begin
            pinOut_r <= 6'h00;
            pinOe_r <= 6'h00;
            pullEn_r <= 6'h00;
            changeFlag_r <= 1'b0;
        end else begin
            pinOut_r <= outNxt;
            pinOe_r <= oeNxt;
            pullEn_r <= pullNxt;
            changeFlag_r <= intCtl_r[CHG_FLAG_BIT];
        end
    end

    // ------------------------------------------------------------
    // eeprom link: a released line reads high, a zero pulls low
    // ------------------------------------------------------------
    // data may follow its latch while the clock is held low, or
    // while the clock is already high and stays high (start/stop)
    wire dataMayMove = eeClockOe_r
                     || (latch_r[EE_CLOCK_BIT] && !eeClockOe_r);
    // the clock may rise only after the data line has settled
    wire dataSettled = (eeDataOe_r == !latch_r[EE_DATA_BIT]);
    wire clockMayMove = !latch_r[EE_CLOCK_BIT] || dataSettled;

    always_ff @(posedge mclk) begin
        if (rst) begin
            eeDataOe_r <= 1'b0;
            eeClockOe_r <= 1'b0;
        end else begin
            // data moves under a low clock, or under a high clock that stays high
            if (dataMayMove) begin
                eeDataOe_r <= !latch_r[EE_DATA_BIT];
            end
            if (clockMayMove) begin
                eeClockOe_r <= !latch_r[EE_CLOCK_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign readdata = readdata_r;
    assign waitrequest = waitreq_r;
    assign pinOut = pinOut_r;
    assign pinOe = pinOe_r;
    assign pullEn = pullEn_r;
    // open drain: the drive value is always low, only the enable moves
    assign eeDataOut = 1'b0;
    assign eeDataOe = eeDataOe_r;
    assign eeClockOut = 1'b0;
    assign eeClockOe = eeClockOe_r;
    assign changeFlag = changeFlag_r;

endmodule
`default_nettype wire

// ---- inc/gpio_port_pkg.sv ----
package gpio_port_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_IDX = 8'h03;
    localparam logic [7:0] PORT_IDX = 8'h05;
    localparam logic [7:0] INTCTL_IDX = 8'h0B;
    localparam logic [7:0] OPTION_IDX = 8'h81;
    localparam logic [7:0] DIR_IDX = 8'h85;
    localparam logic [7:0] CONFIG_IDX = 8'h90;
    localparam logic [7:0] ANALOG_IDX = 8'h91;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] PORT_RST = 8'hC0;
    localparam logic [7:0] INTCTL_RST = 8'h00;
    localparam logic [7:0] OPTION_RST = 8'hFF;
    localparam logic [5:0] DIR_RST = 6'h3F;
    localparam logic [7:0] CONFIG_RST = 8'h04;
    localparam logic [4:0] ANALOG_RST = 5'h17;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STATUS_KEEP_MSB = 5;
    localparam int PULLUP_DIS_BIT = 7;
    localparam int CHG_EN_BIT = 3;
    localparam int CHG_FLAG_BIT = 0;
    localparam int INPUT_ONLY_BIT = 3;
    localparam int EE_DATA_BIT = 6;
    localparam int EE_CLOCK_BIT = 7;
    localparam int CFG_OSC_LSB = 0;
    localparam int CFG_MASTER_CLEAR_INPUT_BIT = 3;
    localparam int CFG_CLOCK_OUTPUT_PIN_BIT = 4;
    localparam logic [5:0] GROUP_MASK = 6'h0B;
    localparam logic [5:0] OSC_PIN_MASK = 6'h30;

    // ------------------------------------------------------------
    // timing: clock output is the instruction rate, mclk / 4
    // ------------------------------------------------------------
    localparam int CLOCK_OUTPUT_PIN_DIV_BITS = 2;

    typedef enum logic [2:0] {
        OSC_LP = 3'h0,
        OSC_XT = 3'h1,
        OSC_HS = 3'h2,
        OSC_INTERNAL_RC_OSC_MODE = 3'h4,
        OSC_EXTERNAL_RC_OSC_MODE = 3'h6
    } osc_mode_t;

endpackage

// ---- tb/board_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module board_model (
    // design side
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    input wire logic eeDataOe,
    input wire logic eeClockOe,
    // board side
    input wire logic [5:0] extLevel,
    output logic [5:0] pinLevel,
    output logic eeData,
    output logic eeClock
);
    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // an enabled driver wins
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extLevel);
    // pulled-up lines; eeprom never drives so it cannot break ordering
    assign eeData = ~eeDataOe;
    assign eeClock = ~eeClockOe;
endmodule
`default_nettype wire

// ---- tb/gpio_port_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpio_port_bench
    import gpio_port_pkg::*;
;
    logic mclk, rst, read, write, waitrequest, changeFlag;
    logic [9:0] address;
    logic [31:0] writedata, readdata;
    logic eeDataOut, eeDataOe, eeClockOut, eeClockOe, eeData, eeClock;
    logic [5:0] pinOut, pinOe, pullEn, extLevel, pinLevel;
    logic [7:0] rdVal;
    int num_errors, n_tests;

    gpio_port dut_u (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOe(pinOe), .pullEn(pullEn),
        .eeDataIn(eeData), .eeDataOut(eeDataOut), .eeDataOe(eeDataOe),
        .eeClockIn(eeClock), .eeClockOut(eeClockOut), .eeClockOe(eeClockOe),
        .changeFlag(changeFlag));
    board_model board_u (.pinOut(pinOut), .pinOe(pinOe), .eeDataOe(eeDataOe),
        .eeClockOe(eeClockOe), .extLevel(extLevel), .pinLevel(pinLevel),
        .eeData(eeData), .eeClock(eeClock));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one idle edge first, so a release is never re-driven in the same step
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] data,
        output logic [7:0] q);
        int n;
        @(posedge mclk);
        address <= {idx, 2'b00};
        read <= !wr;
        write <= wr;
        writedata <= {24'h00_0000, data};
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        q = readdata[7:0];
        if (n >= 20) begin
            num_errors++;
            $display("ERROR at %0t: bus access not answered", $time);
        end
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        logic [7:0] unused;
        bus(1'b1, idx, data, unused);
    endtask

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string what);
        bus(1'b0, idx, 8'h00, rdVal);
        chk(rdVal, exp, what);
    endtask

    // pin levels need the input synchroniser to catch up
    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #100000;
        num_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        end_sim;
    end

    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 10'h000;
        writedata = 32'h0000_0000;
        extLevel = 6'h2A;
        num_errors = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        settle;
        rdc(DIR_IDX, 8'h3F, "direction reset");
        rdc(OPTION_IDX, 8'hFF, "option reset");
        rdc(PORT_IDX, 8'hE8, "port after reset");
        chk({2'b00, pinOe}, 8'h00, "no drive after reset");
        wr(8'h40, 8'hFF);
        rdc(8'h40, 8'h00, "unmapped read");
        $display("test reset done");
        wr(ANALOG_IDX, 8'h00);
        wr(PORT_IDX, 8'hD5);
        wr(DIR_IDX, 8'h00);
        settle;
        chk({2'b00, pinOe}, 8'h37, "drive enables");
        chk({2'b00, pinOut & pinOe}, 8'h15, "drive values");
        rdc(DIR_IDX, 8'h08, "input-only direction");
        rdc(PORT_IDX, 8'hDD, "port driven");
        wr(DIR_IDX, 8'h3E);
        settle;
        rdc(PORT_IDX, 8'hEB, "port mixed");
        wr(PORT_IDX, rdVal);
        wr(DIR_IDX, 8'h00);
        settle;
        chk({2'b00, pinOut & pinOe}, 8'h23, "latches rewritten");
        $display("test drive done");
        wr(CONFIG_IDX, {5'h00, OSC_XT});
        wr(DIR_IDX, 8'h00);
        settle;
        rdc(DIR_IDX, 8'h38, "direction forced");
        chk({2'b00, pinOe}, 8'h07, "oscillator pins released");
        rdc(PORT_IDX, 8'hCB, "oscillator pins read zero");
        wr(CONFIG_IDX, 8'h04);
        wr(DIR_IDX, 8'h00);
        wr(CONFIG_IDX, 8'h14);
        wr(DIR_IDX, 8'h10);
        rdc(DIR_IDX, 8'h08, "direction four frozen");
        $display("test oscillator done");
        wr(CONFIG_IDX, 8'h0C);
        wr(DIR_IDX, 8'h3F);
        settle;
        chk({2'b00, pullEn}, 8'h08, "master clear pull-up");
        rdc(PORT_IDX, 8'hE2, "master clear reads zero");
        wr(OPTION_IDX, 8'h7F);
        settle;
        chk({2'b00, pullEn}, 8'h0B, "group pull-ups");
        wr(CONFIG_IDX, 8'h04);
        wr(OPTION_IDX, 8'hFF);
        settle;
        chk({2'b00, pullEn}, 8'h00, "pull-ups off");
        $display("test pull-up done");
        wr(INTCTL_IDX, 8'h08);
        rdc(PORT_IDX, 8'hEA, "snapshot read");
        // clear what an older snapshot may have flagged
        wr(INTCTL_IDX, 8'h08);
        settle;
        chk({7'h00, changeFlag}, 8'h00, "no change yet");
        extLevel <= 6'h28;
        settle;
        chk({7'h00, changeFlag}, 8'h01, "change seen");
        rdc(INTCTL_IDX, 8'h09, "flag in control");
        rdc(PORT_IDX, 8'hE8, "snapshot read off");
        wr(INTCTL_IDX, 8'h00);
        extLevel <= 6'h2A;
        settle;
        chk({7'h00, changeFlag}, 8'h00, "disabled no flag");
        $display("test change done");
        wr(PORT_IDX, 8'h80);
        wr(PORT_IDX, 8'h00);
        wr(PORT_IDX, 8'h40);
        settle;
        chk({6'h00, eeClockOe, eeDataOe}, 8'h02, "clock low data high");
        rdc(PORT_IDX, 8'h6A, "eeprom line levels");
        wr(PORT_IDX, 8'hC0);
        $display("test eeprom done");
        end_sim;
    end
endmodule
`default_nettype wire

// ---- tb/gpio_port_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
module gpio_port_chk
    import gpio_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register bus
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // general pins
    input wire logic [5:0] pinIn,
    input wire logic [5:0] pinOut,
    input wire logic [5:0] pinOe,
    input wire logic [5:0] pullEn,
    // eeprom link
    input wire logic eeDataIn,
    input wire logic eeDataOut,
    input wire logic eeDataOe,
    input wire logic eeClockIn,
    input wire logic eeClockOut,
    input wire logic eeClockOe,
    // change detect
    input wire logic changeFlag
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence acc_done;
        !waitrequest ##1 waitrequest;
    endsequence

    bus_wait_a: assert property ((read || write) && waitrequest |=> acc_done)
        else $error("access not answered after one wait cycle");
    rst_idle_a: assert property (@(posedge mclk) disable iff (1'b0)
        rst |=> waitrequest && pinOe == 6'h00 && changeFlag == 1'b0)
        else $error("outputs not idle after reset");
    read_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    in_only_a: assert property (pinOe[INPUT_ONLY_BIT] == 1'b0)
        else $error("input-only pin driven");
    pull_group_a: assert property ((pullEn & ~GROUP_MASK) == 6'h00)
        else $error("pull-up outside the group");
    ee_drive_a: assert property (eeDataOut == 1'b0 && eeClockOut == 1'b0)
        else $error("eeprom line driven high");
    ee_order_a: assert property ($changed(eeClockOe) |-> $stable(eeDataOe))
        else $error("eeprom data moved with the clock edge");
    oe_write_a: assert property ($changed(pinOe) |-> $past(write && !waitrequest, 2))
        else $error("drive enable changed without a write");
endmodule
bind gpio_port gpio_port_chk chk_u (.*);
`default_nettype wire
